/* File: core/bls_pkg.sv */
// constants, carrier types and register map of the backlight register bank
// Functional notes
// - full-scale current code, 8 bits RW, 2% at zero to 100% at all ones
// - full-scale current code resets to 00111011, about a quarter scale
// - fault bit 7 is read-only diode open flag, zero after reset
// - fault bit 6 is read-only output over-voltage flag, zero after reset
// - fault bit 5 is read-only converter over-current flag, zero at reset
// - fault bit 4 is read-only string short flag, zero after reset
// - fault bit 3 is read-only string open flag, zero after reset
// - fault bit 2 is read-only over-temperature flag, zero after reset
// - fault bits 1:0 hold the two low dimming bits, RW, reset to 11
// - address 4 holds eight high dimming bits, RW, reset 7F
// - threshold bits 7:3 give over-voltage limit 18V to 80V, reset 11100
// - threshold bits 2:0 give current-limit sense 0.15V to 0.5V, reset 111
// - address 6 always reads the fixed maker code, writes ignored
// - frequency code 0 stops converter, 1 to 9 give 100 to 900 kHz
// - source bit 0: current follows external PWM, scaled by full scale
// - source bit 1: current scaled by full scale and 10-bit dim level
// - source bit is bit 2 of address 0, zero selects PWM, resets 0
// - frequency code is bits 3:0 of address 1, RW, resets to 0100
package bls_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIM_W  = 10;
  localparam int unsigned LVL_W  = 16;

  localparam logic [7:0] ADDR_DIM_MODE   = 8'h00;
  localparam logic [7:0] ADDR_SWITCH     = 8'h01;
  localparam logic [7:0] ADDR_FULL_SCALE = 8'h02;
  localparam logic [7:0] ADDR_FAULT      = 8'h03;
  localparam logic [7:0] ADDR_DIM_HIGH   = 8'h04;
  localparam logic [7:0] ADDR_THRESH     = 8'h05;
  localparam logic [7:0] ADDR_MAKER      = 8'h06;

  localparam int unsigned LED_EN_LSB  = 4;
  localparam int unsigned SPARE_BIT   = 3;
  localparam int unsigned DIM_SRC_BIT = 2;
  localparam int unsigned OCPM_BIT    = 7;
  localparam int unsigned SHORT_LSB   = 4;
  localparam int unsigned OV_LSB      = 3;
  localparam int unsigned FAULT_LSB   = 2;

  localparam logic [3:0] LED_EN_RST     = 4'hF;
  localparam logic [1:0] DIM_MODE_RST   = 2'h0;
  localparam logic       DIM_SRC_RST    = 1'b0;
  localparam logic       OCPM_RST       = 1'b0;
  localparam logic [2:0] SHORT_THR_RST  = 3'h4;
  localparam logic [3:0] FREQ_RST       = 4'h4;
  localparam logic [7:0] FULL_SCALE_RST = 8'h3B;
  localparam logic [1:0] DIM_LOW_RST    = 2'h3;
  localparam logic [7:0] DIM_HIGH_RST   = 8'h7F;
  localparam logic [4:0] OV_RST         = 5'h1C;
  localparam logic [2:0] CL_RST         = 3'h7;

  localparam int unsigned CLK_KHZ       = 100000;
  localparam int unsigned SW_STEP_KHZ   = 100;
  localparam logic [3:0]  FREQ_CODE_MAX = 4'h9;
  localparam logic [15:0] FS_MIN_Q16    = 16'h051F;
  localparam logic [15:0] FS_STEP_Q16   = 16'h00FB;

  typedef struct packed {
    logic diode_open_flag;
    logic overvoltage_flag;
    logic overcurrent_flag;
    logic string_short_flag;
    logic string_open_flag;
    logic over_temp_flag;
  } bls_fault_s;

  typedef struct packed {
    logic [3:0] led_enable;
    logic       spare;
    logic       dim_src;
    logic [1:0] dim_mode;
    logic       ocp_recover;
    logic [2:0] short_thr_code;
    logic [3:0] switch_freq_code;
    logic [7:0] full_scale_code;
    logic [9:0] dim_level;
    logic [4:0] overvoltage_threshold_code;
    logic [2:0] current_limit_code;
  } bls_cfg_s;
endpackage

/* File: core/bls_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bls_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import bls_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

  agree_a: assert property (@(posedge mclk) disable iff (reset)
    (stage2 == stage3) |=> (sync_out == $past(stage3)))
    else $error("synchroniser output not following agreed stages");
endmodule

/* File: core/bls_scale.sv */
// string current level from full-scale code, dimming level and source
`timescale 1ns/1ps
module bls_scale (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic [7:0]               full_scale_code,
  input  wire logic [bls_pkg::DIM_W-1:0] dim_level,
  input  wire logic                     dim_src,
  input  wire logic                     pwm_level,
  output logic      [bls_pkg::LVL_W-1:0] string_level
);
  import bls_pkg::*;

  function automatic logic [15:0] fs_ratio(input logic [7:0] code);
    logic [23:0] prod;
    prod = 24'(code) * 24'(FS_STEP_Q16);
    return 16'(FS_MIN_Q16 + prod[15:0]);
  endfunction

  logic [15:0] fs_q16;
  logic [25:0] mixed;

  assign fs_q16 = fs_ratio(full_scale_code);
  assign mixed  = 26'(fs_q16) * 26'(dim_level);

  always_ff @(posedge mclk) begin
    if (reset) begin
      string_level <= '0;
    end else if (dim_src) begin
      string_level <= mixed[25:10];
    end else begin
      string_level <= pwm_level ? fs_q16 : '0;
    end
  end

  pwm_track_a: assert property (@(posedge mclk) disable iff (reset)
    !dim_src |=> (string_level ==
      ($past(pwm_level) ? fs_ratio($past(full_scale_code)) : 16'h0000)))
    else $error("pwm mode level wrong");
  dim_mix_a: assert property (@(posedge mclk) disable iff (reset)
    dim_src && (dim_level == 10'h000) |=> (string_level == 16'h0000))
    else $error("register mode level not zero at zero dim");
endmodule

/* File: core/bls_regs.sv */
// backlight controller configuration and status register bank
`timescale 1ns/1ps
module bls_regs #(
  parameter logic [7:0] MAKER_CODE = 8'hA5 // arbitrary value
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic [bls_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [bls_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [bls_pkg::DATA_W-1:0] reg_rdata,
  input  wire bls_pkg::bls_fault_s        fault_in,
  input  wire logic                       pwm_in,
  output bls_pkg::bls_cfg_s               cfg,
  output logic      [bls_pkg::LVL_W-1:0]  string_level,
  output logic                            converter_on,
  output logic                            switch_tick
);
  import bls_pkg::*;

  function automatic logic freq_valid(input logic [3:0] code);
    return (code != 4'h0) && (code <= FREQ_CODE_MAX);
  endfunction

  function automatic logic [9:0] sw_period(input logic [3:0] code);
    logic [9:0] p;
    p = 10'h3FF;
    for (int i = 1; i <= int'(FREQ_CODE_MAX); i++) begin
      if (code == 4'(i)) begin
        p = 10'(CLK_KHZ / (SW_STEP_KHZ * i));
      end
    end
    return p;
  endfunction

  logic        wr_dim_mode;
  logic        wr_switch;
  logic        wr_full_scale;
  logic        wr_fault;
  logic        wr_dim_high;
  logic        wr_thresh;
  bls_fault_s  fault_state;
  logic [5:0]  fault_sync;
  logic [0:0]  pwm_sync;
  logic [1:0]  dim_low;
  logic [7:0]  dim_high;
  logic [9:0]  sw_count;
  logic [9:0]  period;
  logic [7:0]  next_rdata;

  assign wr_dim_mode   = reg_wr && (reg_addr == ADDR_DIM_MODE);
  assign wr_switch     = reg_wr && (reg_addr == ADDR_SWITCH);
  assign wr_full_scale = reg_wr && (reg_addr == ADDR_FULL_SCALE);
  assign wr_fault      = reg_wr && (reg_addr == ADDR_FAULT);
  assign wr_dim_high   = reg_wr && (reg_addr == ADDR_DIM_HIGH);
  assign wr_thresh     = reg_wr && (reg_addr == ADDR_THRESH);

  // fault levels and the pwm pin arrive from outside the clock domain
  bls_sync #(
    .W        (6)
  ) u_fault_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (fault_in),
    .sync_out (fault_sync)
  );

  bls_sync #(
    .W        (1)
  ) u_pwm_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (pwm_in),
    .sync_out (pwm_sync)
  );

  assign fault_state = bls_fault_s'(fault_sync);

  // dimming mode register
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg.led_enable <= LED_EN_RST;
      cfg.spare      <= 1'b0;
      cfg.dim_src    <= DIM_SRC_RST;
      cfg.dim_mode   <= DIM_MODE_RST;
    end else if (wr_dim_mode) begin
      cfg.led_enable <= reg_wdata[LED_EN_LSB +: 4];
      cfg.spare      <= reg_wdata[SPARE_BIT];
      cfg.dim_src    <= reg_wdata[DIM_SRC_BIT];
      cfg.dim_mode   <= reg_wdata[1:0];
    end
  end

  // switching and protection mode register
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg.ocp_recover      <= OCPM_RST;
      cfg.short_thr_code   <= SHORT_THR_RST;
      cfg.switch_freq_code <= FREQ_RST;
    end else if (wr_switch) begin
      cfg.ocp_recover      <= reg_wdata[OCPM_BIT];
      cfg.short_thr_code   <= reg_wdata[SHORT_LSB +: 3];
      cfg.switch_freq_code <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg.full_scale_code <= FULL_SCALE_RST;
    end else if (wr_full_scale) begin
      cfg.full_scale_code <= reg_wdata;
    end
  end

  // only the low dimming bits take a write here
  always_ff @(posedge mclk) begin
    if (reset) begin
      dim_low <= DIM_LOW_RST;
    end else if (wr_fault) begin
      dim_low <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dim_high <= DIM_HIGH_RST;
    end else if (wr_dim_high) begin
      dim_high <= reg_wdata;
    end
  end

  assign cfg.dim_level = {dim_high, dim_low};

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg.overvoltage_threshold_code <= OV_RST;
      cfg.current_limit_code         <= CL_RST;
    end else if (wr_thresh) begin
      cfg.overvoltage_threshold_code <= reg_wdata[OV_LSB +: 5];
      cfg.current_limit_code         <= reg_wdata[2:0];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ADDR_DIM_MODE:   next_rdata = {cfg.led_enable, cfg.spare,
                                     cfg.dim_src, cfg.dim_mode};
      ADDR_SWITCH:     next_rdata = {cfg.ocp_recover, cfg.short_thr_code,
                                     cfg.switch_freq_code};
      ADDR_FULL_SCALE: next_rdata = cfg.full_scale_code;
      ADDR_FAULT:      next_rdata = {fault_state, dim_low};
      ADDR_DIM_HIGH:   next_rdata = dim_high;
      ADDR_THRESH:     next_rdata = {cfg.overvoltage_threshold_code,
                                     cfg.current_limit_code};
      ADDR_MAKER:      next_rdata = MAKER_CODE;
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // converter enable and switching-rate divider
  assign period = sw_period(cfg.switch_freq_code);

  always_ff @(posedge mclk) begin
    if (reset) begin
      converter_on <= 1'b0;
    end else begin
      converter_on <= freq_valid(cfg.switch_freq_code);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !freq_valid(cfg.switch_freq_code)) begin
      sw_count    <= 10'h000;
      switch_tick <= 1'b0;
    end else if (sw_count >= period - 10'h001) begin
      sw_count    <= 10'h000;
      switch_tick <= 1'b1;
    end else begin
      sw_count    <= sw_count + 10'h001;
      switch_tick <= 1'b0;
    end
  end

  bls_scale u_scale (
    .mclk            (mclk),
    .reset           (reset),
    .full_scale_code (cfg.full_scale_code),
    .dim_level       (cfg.dim_level),
    .dim_src         (cfg.dim_src),
    .pwm_level       (pwm_sync[0]),
    .string_level    (string_level)
  );

  // helper: cycles between ticks while the code holds still
  logic [9:0] tick_gap;
  logic       gap_valid;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_gap  <= 10'h000;
      gap_valid <= 1'b0;
    end else begin
      tick_gap <= switch_tick ? 10'h000 : tick_gap + 10'h001;
      if (wr_switch) begin
        gap_valid <= 1'b0;
      end else if (switch_tick) begin
        gap_valid <= 1'b1;
      end
    end
  end

  // reset values and bus writes
  reset_vals_a: assert property (
    @(posedge mclk) disable iff (reset)
    $fell(reset) |-> (cfg.full_scale_code == FULL_SCALE_RST) &&
      (dim_low == DIM_LOW_RST) && (dim_high == DIM_HIGH_RST) &&
      (cfg.dim_src == DIM_SRC_RST) && (cfg.led_enable == LED_EN_RST) &&
      (cfg.switch_freq_code == FREQ_RST) &&
      (cfg.overvoltage_threshold_code == OV_RST) &&
      (cfg.current_limit_code == CL_RST) && (reg_rdata == 8'h00) &&
      !converter_on && !switch_tick)
    else $error("register reset values wrong");
  fs_write_a: assert property (
    @(posedge mclk) disable iff (reset)
    wr_full_scale |=> (cfg.full_scale_code == $past(reg_wdata)))
    else $error("full scale code not written");
  fs_hold_a: assert property (
    @(posedge mclk) disable iff (reset)
    !wr_full_scale |=> $stable(cfg.full_scale_code))
    else $error("full scale code changed without write");
  dim_low_a: assert property (
    @(posedge mclk) disable iff (reset)
    wr_fault |=> (dim_low == $past(reg_wdata[1:0])) &&
      (fault_sync == $past(u_fault_sync.stage3, 1) ||
       fault_sync == $past(fault_sync)))
    else $error("fault register write wrong");
  dim_high_a: assert property (
    @(posedge mclk) disable iff (reset)
    wr_dim_high ##1 !wr_dim_high |=> (dim_high == $past(reg_wdata, 2)))
    else $error("high dimming bits not held");
  dim_hold_a: assert property (
    @(posedge mclk) disable iff (reset)
    !wr_fault && !wr_dim_high |=> $stable(cfg.dim_level))
    else $error("dimming level changed without write");
  thresh_a: assert property (
    @(posedge mclk) disable iff (reset)
    wr_thresh |=> (cfg.overvoltage_threshold_code ==
      $past(reg_wdata[7:3])) &&
      (cfg.current_limit_code == $past(reg_wdata[2:0])))
    else $error("threshold register not written");
  src_write_a: assert property (
    @(posedge mclk) disable iff (reset)
    wr_dim_mode |=> (cfg.dim_src == $past(reg_wdata[DIM_SRC_BIT])) &&
      (cfg.led_enable == $past(reg_wdata[7:4])))
    else $error("dimming mode register not written");
  freq_write_a: assert property (
    @(posedge mclk) disable iff (reset)
    wr_switch |=> (cfg.switch_freq_code == $past(reg_wdata[3:0])) &&
      (cfg.short_thr_code == $past(reg_wdata[6:4])))
    else $error("frequency register not written");

  // read path
  fs_read_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_FULL_SCALE) |=>
      (reg_rdata == $past(cfg.full_scale_code)))
    else $error("full scale code read wrong");
  fault_read_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_FAULT) |=>
      (reg_rdata[7:FAULT_LSB] == $past(fault_sync)) &&
      (reg_rdata[1:0] == $past(dim_low)))
    else $error("fault register read wrong");
  dim_read_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_DIM_HIGH) |=>
      (reg_rdata == $past(dim_high)))
    else $error("high dimming bits read wrong");
  thresh_read_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_THRESH) |=>
      (reg_rdata == {$past(cfg.overvoltage_threshold_code),
                     $past(cfg.current_limit_code)}))
    else $error("threshold register read wrong");
  src_read_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_DIM_MODE) |=>
      (reg_rdata[DIM_SRC_BIT] == $past(cfg.dim_src)))
    else $error("dimming source bit read wrong");
  freq_read_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_SWITCH) |=>
      (reg_rdata[3:0] == $past(cfg.switch_freq_code)))
    else $error("frequency code read wrong");
  maker_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_MAKER) |=> (reg_rdata == MAKER_CODE))
    else $error("maker code read wrong");
  unmapped_a: assert property (
    @(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr > ADDR_MAKER) |=> (reg_rdata == 8'h00))
    else $error("unmapped address read not zero");
  rdata_hold_a: assert property (
    @(posedge mclk) disable iff (reset)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  // switching output
  conv_on_a: assert property (
    @(posedge mclk) disable iff (reset)
    freq_valid(cfg.switch_freq_code) |=> converter_on)
    else $error("converter off on a run code");
  conv_off_a: assert property (
    @(posedge mclk) disable iff (reset)
    !freq_valid(cfg.switch_freq_code) |=> !converter_on && !switch_tick)
    else $error("converter running on stop code");
  tick_pulse_a: assert property (
    @(posedge mclk) disable iff (reset)
    switch_tick |=> !switch_tick)
    else $error("switching tick longer than one cycle");
  tick_rate_a: assert property (
    @(posedge mclk) disable iff (reset)
    switch_tick && gap_valid && !wr_switch && !$past(wr_switch) |->
      (tick_gap == period - 10'h001))
    else $error("switching tick period wrong");

  fs_write_c: cover property (@(posedge mclk) disable iff (reset)
    wr_full_scale);
  fault_seen_c: cover property (@(posedge mclk) disable iff (reset)
    reg_rd && (reg_addr == ADDR_FAULT) && (fault_sync != 6'h00));
  tick_c: cover property (@(posedge mclk) disable iff (reset)
    switch_tick && gap_valid);
  src_reg_c: cover property (@(posedge mclk) disable iff (reset)
    $rose(cfg.dim_src));
  off_code_c: cover property (@(posedge mclk) disable iff (reset)
    cfg.switch_freq_code > FREQ_CODE_MAX);
endmodule

/* File: bench/bls_host_model.sv */
// register host model driving the strobe port of the bank
`timescale 1ns/1ps
module bls_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // stale data must not look valid after the strobe
    reg_wdata <= ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the backlight register bank
`timescale 1ns/1ps
module testbench;
  import bls_pkg::*;
  logic              mclk;
  logic              reset;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata;
  bls_fault_s        fault_in;
  logic              pwm_in;
  bls_cfg_s          cfg;
  logic [LVL_W-1:0]  string_level;
  logic              converter_on;
  logic              switch_tick;
  int                failures;
  int                samples_checked;

  bls_regs uut (
    .mclk         (mclk),
    .reset        (reset),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .fault_in     (fault_in),
    .pwm_in       (pwm_in),
    .cfg          (cfg),
    .string_level (string_level),
    .converter_on (converter_on),
    .switch_tick  (switch_tick)
  );

  bls_host_model host (
    .mclk      (mclk),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read(a, d);
    check($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
  endtask

  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_reset_values();
    check("dim level", {6'h00, cfg.dim_level}, 16'h01FF);
    check("fs code", {8'h00, cfg.full_scale_code}, 16'h003B);
    rd_check(8'h00, 8'hF0);
    rd_check(8'h01, 8'h44);
    rd_check(8'h02, 8'h3B);
    rd_check(8'h03, 8'h03);
    rd_check(8'h04, 8'h7F);
    rd_check(8'h05, 8'hE7);
    rd_check(8'h06, 8'hA5);
  endtask

  task automatic t_rw_access();
    host.write(8'h02, 8'h00);
    rd_check(8'h02, 8'h00);
    host.write(8'h02, 8'hFF);
    rd_check(8'h02, 8'hFF);
    host.write(8'h05, 8'h00);
    rd_check(8'h05, 8'h00);
    host.write(8'h05, 8'hFF);
    rd_check(8'h05, 8'hFF);
    host.write(8'h04, 8'h00);
    rd_check(8'h04, 8'h00);
    host.write(8'h06, 8'h5A);
    rd_check(8'h06, 8'hA5);
    host.write(8'h07, 8'h33);
    rd_check(8'h07, 8'h00);
  endtask

  task automatic t_fault_flags();
    for (int i = 0; i < 6; i++) begin
      fault_in <= bls_fault_s'(6'h01 << i);
      settle();
      rd_check(8'h03, {6'h01<<i, 2'h3});
    end
    fault_in <= bls_fault_s'(6'h2A);
    settle();
    host.write(8'h03, 8'hFC);
    rd_check(8'h03, 8'hA8);
    fault_in <= bls_fault_s'(6'h00);
    settle();
    rd_check(8'h03, 8'h00);
  endtask

  task automatic t_level();
    logic [15:0] fs;
    logic [25:0] prod;
    fs = FS_MIN_Q16 + 16'(8'hFF) * FS_STEP_Q16;
    host.write(8'h02, 8'hFF);
    pwm_in <= 1'b1;
    settle();
    check("pwm high level", string_level, fs);
    pwm_in <= 1'b0;
    settle();
    check("pwm low level", string_level, 16'h0000);
    host.write(8'h00, 8'hF4);
    host.write(8'h04, 8'h80);
    host.write(8'h03, 8'h01);
    settle();
    check("dim src", {15'h0000, cfg.dim_src}, 16'h0001);
    check("dim pair", {6'h00, cfg.dim_level}, 16'h0201);
    prod = 26'(fs) * 26'h201;
    check("reg level", string_level, prod[25:10]);
    host.write(8'h02, 8'h00);
    settle();
    prod = 26'(FS_MIN_Q16) * 26'h201;
    check("reg min level", string_level, prod[25:10]);
  endtask

  task automatic tick_gap(output int n);
    int k;
    k = 0;
    while (switch_tick !== 1'b1 && k < 2100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    @(posedge mclk);
    #1;
    n = 1;
    while (switch_tick !== 1'b1 && n < 2100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 2100 || k >= 2100) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic t_switching();
    int  n;
    int  ticks;
    logic on;
    for (int c = 0; c < 16; c++) begin
      host.write(8'h01, {4'h4, 4'(c)});
      @(posedge mclk);
      #1;
      on = (c >= 1 && c <= 9);
      check("conv on", 16'(converter_on), 16'(on));
      if (!on) begin
        ticks = 0;
        repeat (1100) begin
          @(posedge mclk);
          #1;
          if (switch_tick !== 1'b0) ticks++;
        end
        check("off ticks", 16'(ticks), 16'h0000);
      end else if (c == 1 || c == 4 || c == 9) begin
        tick_gap(n);
        check("tick period", 16'(n), 16'(1000 / c));
      end
    end
  endtask

  initial begin
    failures        = 0;
    samples_checked = 0;
    reset           = 1'b1;
    fault_in        = bls_fault_s'(6'h00);
    pwm_in          = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset_values();
    t_rw_access();
    t_fault_flags();
    t_level();
    t_switching();
    print_verdict();
  end
endmodule
